// file: rtl/power_loss_reset_sequencer.v
`timescale 1ns/1ps
`include "reset_seq_defs.vh"

module power_loss_reset_sequencer #(
	parameter PG_DELAY_CYC = `PG_ASSERT_DELAY_CYC,
	parameter MIN_WIDTH_CYC = `RST_MIN_WIDTH_CYC,
	parameter PG_MIN_LOW_CYC = `PG_MIN_LOW_CYC,
	parameter PARK_WAIT_CYC = 16,
	parameter CNT_W = 20
) (
	input wire sys_clk,
	input wire rst,
	input wire power_on_sense,
	input wire supply_ok_warning,
	input wire chip_tristate_enable,
	input wire test_logic_reset_n,
	input wire sw_general_release,
	input wire sw_motor_release,
	input wire sw_general_force,
	input wire sw_motor_force,
	input wire internal_reset_req,
	input wire park_done,
	input wire [7:0] debug_test_out,
	input wire [7:0] debug_test_oe,
	output reg general_reset_out_n,
	output reg general_reset_oe,
	output reg motor_reset_out_n,
	output reg motor_reset_oe,
	output reg ctrl_reset,
	output reg park_req,
	output reg [7:0] debug_test_pin_out,
	output reg [7:0] debug_test_pin_oe,
	output reg scan_mode
);
	localparam [3:0] ST_RUN = 4'b0001;
	localparam [3:0] ST_QUAL = 4'b0010;
	localparam [3:0] ST_PARK = 4'b0100;
	localparam [3:0] ST_RESET = 4'b1000;

	wire [2:0] sync_w;
	wire pos_s;
	wire pg_s;
	wire tri_s;

	// power-on sense and power-good reset low so the chip starts held
	level_sync #(.WIDTH(3), .RESET_VAL(3'b000)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({chip_tristate_enable, supply_ok_warning, power_on_sense}),
		.sync_out(sync_w)
	);
	assign pos_s = sync_w[0];
	assign pg_s = sync_w[1];
	assign tri_s = sync_w[2];

	function [CNT_W-1:0] cnt_dec;
		input [CNT_W-1:0] c;
		begin
			cnt_dec = (c == {CNT_W{1'b0}}) ? c : c - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	endfunction

	reg [3:0] state_q, state_d;
	reg [CNT_W-1:0] qual_q, qual_d;
	reg [CNT_W-1:0] pgdly_q, pgdly_d;
	reg pgdly_run_q, pgdly_run_d;
	reg pg_fire;

	// power-good low qualification and park sequencing
	always @* begin
		state_d = state_q;
		qual_d = qual_q;
		case (state_q)
			ST_RUN: begin
				if (!pg_s) begin
					state_d = ST_QUAL;
					qual_d = PG_MIN_LOW_CYC[CNT_W-1:0];
				end
			end
			ST_QUAL: begin
				if (pg_s) begin
					state_d = ST_RUN;
				end else if (qual_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
					state_d = ST_PARK;
					qual_d = PARK_WAIT_CYC[CNT_W-1:0];
				end else begin
					qual_d = cnt_dec(qual_q);
				end
			end
			ST_PARK: begin
				// park before full reset; bounded wait if no ack arrives
				if (park_done || qual_q == {CNT_W{1'b0}}) begin
					state_d = ST_RESET;
				end else begin
					qual_d = cnt_dec(qual_q);
				end
			end
			ST_RESET: begin
				if (pg_s && pos_s) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
	end

	// 5 us delay from a falling power-good to reset output assertion
	always @* begin
		pgdly_d = pgdly_q;
		pgdly_run_d = pgdly_run_q;
		pg_fire = 1'b0;
		if (pg_s) begin
			pgdly_run_d = 1'b0;
		end else if (!pgdly_run_q && state_q == ST_RUN) begin
			pgdly_run_d = 1'b1;
			pgdly_d = PG_DELAY_CYC[CNT_W-1:0];
		end else if (pgdly_run_q) begin
			if (pgdly_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				pg_fire = 1'b1;
			end
			pgdly_d = cnt_dec(pgdly_q);
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_RESET;
			qual_q <= {CNT_W{1'b0}};
			pgdly_q <= {CNT_W{1'b0}};
			pgdly_run_q <= 1'b0;
		end else begin
			state_q <= state_d;
			qual_q <= qual_d;
			pgdly_q <= pgdly_d;
			pgdly_run_q <= pgdly_run_d;
		end
	end

	// common assertion cause for both reset outputs
	wire assert_cause = !pos_s || pg_fire || internal_reset_req;
	wire gen_cause = assert_cause || sw_general_force;
	wire mot_cause = assert_cause || sw_motor_force;

	// release needs power sense high; a new cause wins over it
	function chan_hold;
		input cause;
		input hold;
		input sw_rel;
		input sense_ok;
		begin
			if (cause) begin
				chan_hold = 1'b1;
			end else if (sw_rel && sense_ok) begin
				chan_hold = 1'b0;
			end else begin
				chan_hold = hold;
			end
		end
	endfunction

	// low while a cause, a software hold or the width count remains
	function chan_low;
		input cause;
		input hold;
		input [CNT_W-1:0] cnt;
		begin
			chan_low = cause || hold || (cnt != {CNT_W{1'b0}});
		end
	endfunction

	// debug enables gated off while power-good low or tristated
	function [7:0] pin_gate;
		input pg_low;
		input float_all;
		input [7:0] want;
		begin
			pin_gate = (pg_low || float_all) ? 8'h00 : want;
		end
	endfunction

	reg gen_hold_q, gen_hold_d;
	reg mot_hold_q, mot_hold_d;
	reg [CNT_W-1:0] gen_cnt_q, gen_cnt_d;
	reg [CNT_W-1:0] mot_cnt_q, mot_cnt_d;
	reg gen_low_q, gen_low_d;
	reg mot_low_q, mot_low_d;

	// width count restarts on every cause cycle, so it runs from the last one
	always @* begin
		gen_hold_d = chan_hold(gen_cause, gen_hold_q, sw_general_release, pos_s);
		gen_cnt_d = gen_cause ? MIN_WIDTH_CYC[CNT_W-1:0] : cnt_dec(gen_cnt_q);
		gen_low_d = chan_low(gen_cause, gen_hold_q, gen_cnt_q);
	end

	always @* begin
		mot_hold_d = chan_hold(mot_cause, mot_hold_q, sw_motor_release, pos_s);
		mot_cnt_d = mot_cause ? MIN_WIDTH_CYC[CNT_W-1:0] : cnt_dec(mot_cnt_q);
		mot_low_d = chan_low(mot_cause, mot_hold_q, mot_cnt_q);
	end

	// both channels start held low after reset
	always @(posedge sys_clk) begin
		if (rst) begin
			gen_hold_q <= 1'b1;
			gen_cnt_q <= MIN_WIDTH_CYC[CNT_W-1:0];
			gen_low_q <= 1'b1;
		end else begin
			gen_hold_q <= gen_hold_d;
			gen_cnt_q <= gen_cnt_d;
			gen_low_q <= gen_low_d;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			mot_hold_q <= 1'b1;
			mot_cnt_q <= MIN_WIDTH_CYC[CNT_W-1:0];
			mot_low_q <= 1'b1;
		end else begin
			mot_hold_q <= mot_hold_d;
			mot_cnt_q <= mot_cnt_d;
			mot_low_q <= mot_low_d;
		end
	end

	// general reset pin; tristate enable floats it
	always @(posedge sys_clk) begin
		if (rst) begin
			general_reset_out_n <= 1'b0;
			general_reset_oe <= 1'b1;
		end else begin
			general_reset_out_n <= !gen_low_q;
			general_reset_oe <= !tri_s;
		end
	end

	// motor reset pin; same gating as the general one
	always @(posedge sys_clk) begin
		if (rst) begin
			motor_reset_out_n <= 1'b0;
			motor_reset_oe <= 1'b1;
		end else begin
			motor_reset_out_n <= !mot_low_q;
			motor_reset_oe <= !tri_s;
		end
	end

	// held while power-good low, and through the reset state; the park state alone does not hold it
	always @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reset <= `CTRL_RST_RESET;
		end else begin
			ctrl_reset <= !pg_s || state_q == ST_RESET;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			park_req <= 1'b0;
		end else begin
			park_req <= (state_q == ST_PARK);
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			debug_test_pin_out <= 8'h00;
		end else begin
			debug_test_pin_out <= debug_test_out;
		end
	end

	// pins float during power loss whatever the debug side wants
	always @(posedge sys_clk) begin
		if (rst) begin
			debug_test_pin_oe <= 8'h00;
		end else begin
			debug_test_pin_oe <= pin_gate(!pg_s, tri_s, debug_test_oe);
		end
	end

	// test reset low is normal mode; high only for scan or debug
	always @(posedge sys_clk) begin
		if (rst) begin
			scan_mode <= 1'b0;
		end else begin
			scan_mode <= test_logic_reset_n;
		end
	end
endmodule // power_loss_reset_sequencer

// file: rtl/reset_seq_defs.vh
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// clock rate in kHz
`define CLK_FREQ_KHZ 125000
// delay from detected power-good fall to reset assertion, in ns
`define PG_ASSERT_DELAY_NS 5000
`define PG_ASSERT_DELAY_CYC ((`PG_ASSERT_DELAY_NS * `CLK_FREQ_KHZ) / 1000000)
// minimum low time of each reset output, in us
`define RST_MIN_WIDTH_US 2000
`define RST_MIN_WIDTH_CYC ((`RST_MIN_WIDTH_US * (`CLK_FREQ_KHZ / 1000)))
// minimum power-good deassertion time treated as real, in ns
`define PG_MIN_LOW_NS 1000
`define PG_MIN_LOW_CYC ((`PG_MIN_LOW_NS * `CLK_FREQ_KHZ) / 1000000)
// synchroniser depth
`define SYNC_STAGES 2
// debug test pin count
`define TEST_PIN_COUNT 8
// reset value of the internal controller reset
`define CTRL_RST_RESET 1'b1

`endif

// file: rtl/level_sync.v
`timescale 1ns/1ps
`include "reset_seq_defs.vh"

// two-stage synchroniser; only the last stage is visible
module level_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire sys_clk,
	input wire rst,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // level_sync

// file: dv/reset_seq_asserts.sv
`timescale 1ns/1ps
module reset_seq_asserts #(
	parameter MIN_WIDTH_CYC = 200,
	parameter PG_MIN_LOW_CYC = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire power_on_sense,
	input wire supply_ok_warning,
	input wire chip_tristate_enable,
	input wire general_reset_out_n,
	input wire motor_reset_out_n,
	input wire general_reset_oe,
	input wire motor_reset_oe,
	input wire ctrl_reset,
	input wire park_req,
	input wire [7:0] debug_test_pin_oe
);
	localparam int PARK_MAX = 24;
	int low_q;
	int pg_low_q;
	always @(posedge sys_clk) begin
		low_q <= (rst || general_reset_out_n) ? 0 : low_q + 1;
		pg_low_q <= supply_ok_warning ? 0 : pg_low_q + 1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// six samples: two sync stages plus cause and output registers
	sequence sense_gone;
		!power_on_sense [*6];
	endsequence
	sequence pg_gone;
		!supply_ok_warning [*6];
	endsequence
	sequence park_start;
		$rose(park_req);
	endsequence
	sense_gen_a: assert property (sense_gone |-> !general_reset_out_n)
		else $error("general reset high with sense low");
	sense_motor_a: assert property (sense_gone |-> !motor_reset_out_n)
		else $error("motor reset high with sense low");
	min_width_a: assert property ($rose(general_reset_out_n) |-> low_q >= MIN_WIDTH_CYC - 2)
		else $error("general reset pulse too short");
	ctrl_hold_a: assert property (pg_gone |-> ctrl_reset)
		else $error("controller not held in reset");
	debug_float_a: assert property (pg_gone |-> debug_test_pin_oe == 8'h00)
		else $error("test pins driven while power-good low");
	tri_float_a: assert property (chip_tristate_enable [*6]
		|-> !general_reset_oe && !motor_reset_oe && debug_test_pin_oe == 8'h00)
		else $error("output driven during tristate");
	park_qual_a: assert property (park_start |-> pg_low_q >= PG_MIN_LOW_CYC)
		else $error("park on short power-good low");
	park_end_a: assert property (park_start |-> ##[1:PARK_MAX] !park_req)
		else $error("park never ends");
endmodule // reset_seq_asserts
bind power_loss_reset_sequencer reset_seq_asserts #(.MIN_WIDTH_CYC(MIN_WIDTH_CYC),
	.PG_MIN_LOW_CYC(PG_MIN_LOW_CYC)) chk (.*);

// file: dv/supply_monitor.sv
`timescale 1ns/1ps
module supply_monitor (
	input wire sys_clk,
	input wire supplies_ok,
	input wire glitch,
	output reg power_on_sense = 1'b1,
	output reg supply_ok_warning = 1'b1
);
	reg [5:0] gap_q = 6'h00;
	// sense may drop only once the warning has led by 40 cycles
	always @(posedge sys_clk) begin
		supply_ok_warning <= supplies_ok && !glitch;
		gap_q <= supply_ok_warning ? 6'h00 : gap_q + {5'h00, gap_q != 6'h28};
		power_on_sense <= supplies_ok || gap_q != 6'h28;
	end
endmodule // supply_monitor

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
	reg sys_clk = 0, rst = 1, sup = 1, glitch = 0, tse = 0, tlr_n = 0, pdone = 0, seen = 0;
	reg g_rel = 0, m_rel = 0, g_frc = 0, m_frc = 0, int_req = 0;
	reg [7:0] dout = 8'h00, doe = 8'h00;
	reg [31:0] seed = 32'h778c_398d;
	wire pos, pg, g_n, m_n, g_oe, m_oe, ctrl, park, scan;
	wire [7:0] pin_out, pin_oe;
	int fail_count = 0, comparisons = 0, i;
	supply_monitor mon (.sys_clk(sys_clk), .supplies_ok(sup), .glitch(glitch),
		.power_on_sense(pos), .supply_ok_warning(pg));
	power_loss_reset_sequencer #(.PG_DELAY_CYC(20), .MIN_WIDTH_CYC(200), .PG_MIN_LOW_CYC(8)) uut (
		.sys_clk(sys_clk), .rst(rst), .power_on_sense(pos), .supply_ok_warning(pg),
		.chip_tristate_enable(tse), .test_logic_reset_n(tlr_n), .sw_general_release(g_rel),
		.sw_motor_release(m_rel), .sw_general_force(g_frc), .sw_motor_force(m_frc),
		.internal_reset_req(int_req), .park_done(pdone), .debug_test_out(dout),
		.debug_test_oe(doe), .general_reset_out_n(g_n), .general_reset_oe(g_oe),
		.motor_reset_out_n(m_n), .motor_reset_oe(m_oe), .ctrl_reset(ctrl), .park_req(park),
		.debug_test_pin_out(pin_out), .debug_test_pin_oe(pin_oe), .scan_mode(scan));
	function automatic [31:0] xs(input [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	function automatic [7:0] exp_oe(input low, input [7:0] want);
		exp_oe = low ? 8'h00 : want;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t bit %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t byte %h not %h", $time, got, exp);
		end
	endtask
	task automatic rel_both;
		tick(1);
		g_rel <= 1;
		m_rel <= 1;
		tick(1);
		g_rel <= 0;
		m_rel <= 0;
		tick(4);
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// prompt park acknowledge from the mirror side
	always @(posedge sys_clk) begin
		pdone <= park;
		if (park === 1'b1)
			seen <= 1;
	end
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#(8 * 5000);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		tick(6);
		rst <= 0;
		tick(300);
		chk1(g_n, 0);
		chk1(m_n, 0);
		rel_both;
		chk1(g_n, 1);
		chk1(m_n, 1);
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			dout <= seed[7:0];
			doe <= seed[15:8];
			glitch <= 1;
			tick(1 + seed[18:16] % 6);
			glitch <= 0;
			tick(40);
			chk8(pin_out, seed[7:0]);
			chk8(pin_oe, exp_oe(0, seed[15:8]));
			chk1(g_n, 1);
			chk1(seen, 0);
		end
		tse <= 1;
		tick(6);
		chk1(g_oe, 0);
		chk1(m_oe, 0);
		chk8(pin_oe, exp_oe(1, doe));
		tse <= 0;
		tlr_n <= 1;
		tick(6);
		chk1(scan, 1);
		chk1(g_oe, 1);
		tlr_n <= 0;
		g_frc <= 1;
		tick(6);
		chk1(g_n, 0);
		chk1(m_n, 1);
		g_frc <= 0;
		int_req <= 1;
		tick(1);
		int_req <= 0;
		tick(8);
		chk1(m_n, 0);
		// released early: only the width count keeps the outputs low now
		rel_both;
		tick(150);
		chk1(g_n, 0);
		tick(60);
		chk1(g_n, 1);
		chk1(m_n, 1);
		glitch <= 1;
		tick(40);
		chk1(g_n, 0);
		chk1(ctrl, 1);
		chk1(seen, 1);
		sup <= 0;
		tick(60);
		chk1(m_n, 0);
		sup <= 1;
		glitch <= 0;
		tick(300);
		chk1(g_n, 0);
		rel_both;
		chk1(g_n, 1);
		chk1(ctrl, 0);
		tally_and_finish;
	end
endmodule // tb
